// ### rtl/ffe_params.svh
`ifndef FFE_PARAMS_SVH
`define FFE_PARAMS_SVH
// configuration port addresses
`define FFE_REG_FILTER_CFG 3'h0
`define FFE_REG_FILTER_LEN 3'h1
`define FFE_REG_COEF_PORT 3'h2
`define FFE_REG_IN_FMT 3'h3
`define FFE_REG_MIX_FMT 3'h7
// field positions
`define FFE_CFG_COEF_RD_BIT 4
`define FFE_IN_FMT_OFFSET_BIT 5
`define FFE_IN_FMT_MSB_FIRST_BIT 6
`define FFE_MIX_FMT_MSB_FIRST_BIT 5
`define FFE_MIX_FMT_SERIAL_BIT 6
// reset values and sizes
`define FFE_REG_RESET 8'h00
`define FFE_COEF_DEPTH 128
`define FFE_COEF_LAST 7'h7F
`define FFE_BYTE_LAST 2'h3
`define FFE_LEN_MIN 5'h08
`define FFE_LEN_MAX 5'h18
`define FFE_MSB_BIT 5'h17
// mix factor rom contents, integer scale so +1 passes data unchanged
`define FFE_ROM_ZERO 24'h00_0000
`define FFE_ROM_POS 24'h00_0001
`define FFE_ROM_NEG 24'hFF_FFFF
`endif

// ### rtl/ffe_pkg.sv
`include "ffe_params.svh"
`default_nettype none
package ffe_pkg;
  typedef logic [23:0] ffe_word_type;
  typedef logic [31:0] ffe_coef_type;
  typedef logic [47:0] ffe_prod_type;
  typedef enum logic [1:0]
  {
    FFE_RX_IDLE = 2'h0,
    FFE_RX_SHIFT = 2'h1,
    FFE_RX_HOLD = 2'h3
  } ffe_rx_state_type;

  // out-of-range word lengths are forced into 8..24
  function automatic logic [4:0] ffe_clamp_len(input logic [4:0] len);
    if (len < `FFE_LEN_MIN)
      return `FFE_LEN_MIN;
    if (len > `FFE_LEN_MAX)
      return `FFE_LEN_MAX;
    return len;
  endfunction : ffe_clamp_len
endpackage : ffe_pkg
`default_nettype wire

// ### rtl/ffe_ser_if.sv
`default_nettype none
interface ffe_ser_if;
  import ffe_pkg::*;
  logic ser_bit;
  logic ser_sync;
  logic [4:0] word_len;
  logic msb_first;
  ffe_word_type aligned;
  ffe_word_type held;
  modport rx (input ser_bit, input ser_sync, input word_len,
              input msb_first, output aligned, output held);
  modport host (output ser_bit, output ser_sync, output word_len,
                output msb_first, input aligned, input held);
endinterface : ffe_ser_if
`default_nettype wire

// ### rtl/ffe_serial_rx.sv
`include "ffe_params.svh"
`default_nettype none
module ffe_serial_rx
(
  input wire logic ser_clk,
  input wire logic nrst,
  ffe_ser_if.rx port
);
  import ffe_pkg::*;
  ffe_rx_state_type state;
  ffe_word_type shreg;
  logic [4:0] count;
  logic [4:0] len;

  assign len = ffe_clamp_len(port.word_len);
  // msb-first words land in the low bits and are moved up; zeros follow
  assign port.aligned = port.msb_first ?
    ffe_word_type'(shreg << (`FFE_LEN_MAX - len)) : shreg;

  // sync starts a word; shifting stops once the word is complete
  always_ff @(posedge ser_clk or negedge nrst)
  begin
    if (!nrst)
      state <= FFE_RX_IDLE;
    else if (port.ser_sync)
      state <= FFE_RX_SHIFT;
    else
    begin
      unique case (state)
        FFE_RX_IDLE, FFE_RX_HOLD: state <= state;
        FFE_RX_SHIFT:
          if (count == len - 5'h01)
            state <= FFE_RX_HOLD;
      endcase
    end
  end

  // shift register, cleared at sync so short words come out zero filled
  always_ff @(posedge ser_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shreg <= '0;
      count <= 5'h00;
    end
    else if (port.ser_sync)
    begin
      shreg <= '0;
      count <= 5'h00;
    end
    else if (state == FFE_RX_SHIFT)
    begin
      shreg <= port.msb_first ? {shreg[22:0], port.ser_bit}
                              : {port.ser_bit, shreg[23:1]};
      count <= count + 5'h01;
    end
  end

  // holding register; a sync held high for two clocks would clear it
  always_ff @(posedge ser_clk or negedge nrst)
  begin
    if (!nrst)
      port.held <= '0;
    else if (port.ser_sync)
      port.held <= port.aligned;
  end

  rx_start_a: assert property (@(posedge ser_clk) disable iff (!nrst)
    port.ser_sync |=> state == FFE_RX_SHIFT && count == 5'h00)
    else $error("shift not started after sync");
  // checked on entry only: a length change while holding is legal
  rx_stop_a: assert property (@(posedge ser_clk) disable iff (!nrst)
    $rose(state == FFE_RX_HOLD) |-> count == len)
    else $error("word length not respected");
  rx_hold_a: assert property (@(posedge ser_clk) disable iff (!nrst)
    port.ser_sync |=> port.held == $past(port.aligned))
    else $error("holding register not loaded at sync");
endmodule : ffe_serial_rx
`default_nettype wire

// ### rtl/ffe_top.sv
`include "ffe_params.svh"
`default_nettype none
module ffe_top
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] reg_select_pins,
  input wire logic [7:0] config_byte_bus_in,
  output logic [7:0] config_byte_bus_out,
  output logic config_byte_bus_oe,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [6:0] coef_rd_addr,
  output ffe_pkg::ffe_coef_type coef_rd_data,
  input wire logic ser_clk,
  input wire logic data_serial_in,
  input wire logic sample_word_sync,
  input wire logic mix_serial_in,
  input wire logic mix_word_sync,
  output ffe_pkg::ffe_prod_type product_data,
  output logic product_valid
);
  import ffe_pkg::*;

  logic wr_m, wr_s, wr_d;
  logic rd_m, rd_s, rd_d;
  logic [2:0] addr_m, addr_s;
  logic [7:0] dat_m, dat_s;
  logic wr_done, rd_start;
  logic wr_other, rd_other, coef_wr, coef_rd, coef_rd_en;
  logic [7:0] cfg_regs [8];
  ffe_coef_type coef_mem [`FFE_COEF_DEPTH];
  logic [23:0] hold_bytes;
  logic [1:0] byte_cnt;
  logic [6:0] wptr;
  logic wr_full;
  logic [8:0] rptr;
  logic [6:0] in_fmt_m, in_fmt_s, mix_fmt_m, mix_fmt_s;
  ffe_word_type rom_out, rom_hold, next_rom, mcand, data_tc;
  ffe_prod_type acc, next_acc, prod_hold, mext;
  logic [4:0] mbit, in_len;
  logic mul_busy, prod_tgl;
  logic tgl_m, tgl_s, tgl_d;

  // pins are asynchronous to sys_clk; two flops before any use
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_m <= 1'b1;
      wr_s <= 1'b1;
      wr_d <= 1'b1;
      rd_m <= 1'b1;
      rd_s <= 1'b1;
      rd_d <= 1'b1;
      addr_m <= 3'h0;
      addr_s <= 3'h0;
      dat_m <= 8'h00;
      dat_s <= 8'h00;
    end
    else
    begin
      wr_m <= wr_n;
      wr_s <= wr_m;
      wr_d <= wr_s;
      rd_m <= rd_n;
      rd_s <= rd_m;
      rd_d <= rd_s;
      addr_m <= reg_select_pins;
      addr_s <= addr_m;
      dat_m <= config_byte_bus_in;
      dat_s <= dat_m;
    end
  end

  // a write completes on the rising write strobe, a read starts on the fall
  assign wr_done = wr_s & ~wr_d;
  assign rd_start = ~rd_s & rd_d;
  assign coef_rd_en = cfg_regs[`FFE_REG_FILTER_CFG][`FFE_CFG_COEF_RD_BIT];
  assign wr_other = wr_done && (addr_s != `FFE_REG_COEF_PORT);
  assign rd_other = rd_start && (addr_s != `FFE_REG_COEF_PORT);
  assign coef_wr = wr_done && (addr_s == `FFE_REG_COEF_PORT) &&
                   !coef_rd_en && !wr_full;
  assign coef_rd = rd_start && (addr_s == `FFE_REG_COEF_PORT) &&
                   coef_rd_en;

  // configuration bytes; the filter engine reads them from here
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 8; i++)
        cfg_regs[i] <= `FFE_REG_RESET;
    end
    else if (wr_other)
      cfg_regs[addr_s] <= dat_s;
  end

  // pointers and byte counter; any other access rewinds everything
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wptr <= 7'h00;
      wr_full <= 1'b0;
      byte_cnt <= 2'h0;
      rptr <= 9'h000;
    end
    else if (wr_other || rd_other)
    begin
      wptr <= 7'h00;
      wr_full <= 1'b0;
      byte_cnt <= 2'h0;
      rptr <= 9'h000;
    end
    else
    begin
      if (coef_wr)
      begin
        byte_cnt <= byte_cnt + 2'h1;
        if (byte_cnt == `FFE_BYTE_LAST)
        begin
          wr_full <= (wptr == `FFE_COEF_LAST);
          if (wptr != `FFE_COEF_LAST)
            wptr <= wptr + 7'h01;
        end
      end
      if (coef_rd)
        rptr <= rptr + 9'h001;
    end
  end

  // low bytes wait in the holding register until the fourth write
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      hold_bytes <= 24'h00_0000;
    else if (coef_wr && byte_cnt != `FFE_BYTE_LAST)
      hold_bytes[{byte_cnt, 3'h0} +: 8] <= dat_s;
  end

  // store has no reset; contents are undefined until loaded
  always_ff @(posedge sys_clk)
  begin
    if (coef_wr && byte_cnt == `FFE_BYTE_LAST)
      coef_mem[wptr] <= {dat_s, hold_bytes};
    coef_rd_data <= coef_mem[coef_rd_addr];
  end

  // read data bus; the host keeps reads and writes apart, and a low write strobe also keeps the driver off
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      config_byte_bus_out <= 8'h00;
      config_byte_bus_oe <= 1'b0;
    end
    else
    begin
      config_byte_bus_oe <= ~rd_s & wr_s;
      if (coef_rd)
        config_byte_bus_out <=
          coef_mem[rptr[8:2]][{rptr[1:0], 3'h0} +: 8];
      else if (rd_start && addr_s == `FFE_REG_COEF_PORT)
        config_byte_bus_out <= 8'h00;
      else if (rd_start)
        config_byte_bus_out <= cfg_regs[addr_s];
    end
  end

  // formats cross as levels; change them only while the link is idle
  always_ff @(posedge ser_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_fmt_m <= 7'h00;
      in_fmt_s <= 7'h00;
      mix_fmt_m <= 7'h00;
      mix_fmt_s <= 7'h00;
    end
    else
    begin
      in_fmt_m <= cfg_regs[`FFE_REG_IN_FMT][6:0];
      in_fmt_s <= in_fmt_m;
      mix_fmt_m <= cfg_regs[`FFE_REG_MIX_FMT][6:0];
      mix_fmt_s <= mix_fmt_m;
    end
  end

  ffe_ser_if smp_if();
  ffe_ser_if mix_if();
  assign smp_if.ser_bit = data_serial_in;
  assign smp_if.ser_sync = sample_word_sync;
  assign smp_if.word_len = in_fmt_s[4:0];
  assign smp_if.msb_first = in_fmt_s[`FFE_IN_FMT_MSB_FIRST_BIT];
  assign mix_if.ser_bit = mix_serial_in;
  assign mix_if.ser_sync = mix_word_sync;
  assign mix_if.word_len = mix_fmt_s[4:0];
  assign mix_if.msb_first = mix_fmt_s[`FFE_MIX_FMT_MSB_FIRST_BIT];

  ffe_serial_rx u_smp_rx
  (
    .ser_clk(ser_clk),
    .nrst(nrst),
    .port(smp_if.rx)
  );

  ffe_serial_rx u_mix_rx
  (
    .ser_clk(ser_clk),
    .nrst(nrst),
    .port(mix_if.rx)
  );

  // selector decode for the quarter-rate sinusoid rom
  always_comb
  begin
    unique case ({mix_word_sync, mix_serial_in})
      2'h0, 2'h2: next_rom = `FFE_ROM_ZERO;
      2'h1: next_rom = `FFE_ROM_NEG;
      2'h3: next_rom = `FFE_ROM_POS;
    endcase
  end

  // rom path adds one sample period of latency by design
  always_ff @(posedge ser_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rom_out <= `FFE_ROM_ZERO;
      rom_hold <= `FFE_ROM_ZERO;
    end
    else if (sample_word_sync)
    begin
      rom_hold <= rom_out;
      rom_out <= next_rom;
    end
  end

  // offset binary becomes two's complement by flipping the sign bit
  assign data_tc = {smp_if.held[23] ^ in_fmt_s[`FFE_IN_FMT_OFFSET_BIT],
                    smp_if.held[22:0]};
  assign in_len = ffe_clamp_len(in_fmt_s[4:0]);
  assign mext = {{24{mcand[23]}}, mcand};

  // one partial product per clock; the sign bit carries negative weight
  always_comb
  begin
    next_acc = acc;
    if (data_tc[mbit] && mbit == `FFE_MSB_BIT)
      next_acc = acc - ffe_prod_type'(mext << mbit);
    else if (data_tc[mbit])
      next_acc = acc + ffe_prod_type'(mext << mbit);
  end

  // only the word's own bits are walked, so short words finish in time
  always_ff @(posedge ser_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mcand <= '0;
      acc <= '0;
      mbit <= 5'h00;
      mul_busy <= 1'b0;
      prod_hold <= '0;
      prod_tgl <= 1'b0;
    end
    else if (sample_word_sync)
    begin
      mcand <= !mix_fmt_s[`FFE_MIX_FMT_SERIAL_BIT] ? rom_hold :
               mix_word_sync ? mix_if.aligned : mix_if.held;
      acc <= '0;
      mbit <= `FFE_LEN_MAX - in_len;
      mul_busy <= 1'b1;
    end
    else if (mul_busy)
    begin
      acc <= next_acc;
      mbit <= mbit + 5'h01;
      if (mbit == `FFE_MSB_BIT)
      begin
        mul_busy <= 1'b0;
        prod_hold <= next_acc;
        prod_tgl <= ~prod_tgl;
      end
    end
  end

  // product word is stable long before the toggle arrives here
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tgl_m <= 1'b0;
      tgl_s <= 1'b0;
      tgl_d <= 1'b0;
      product_valid <= 1'b0;
      product_data <= '0;
    end
    else
    begin
      tgl_m <= prod_tgl;
      tgl_s <= tgl_m;
      tgl_d <= tgl_s;
      product_valid <= tgl_s ^ tgl_d;
      if (tgl_s ^ tgl_d)
        product_data <= prod_hold;
    end
  end

  lsb_first_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    coef_wr && byte_cnt == 2'h0 |=> hold_bytes[7:0] == $past(dat_s))
    else $error("first byte not in low lane");
  coef_commit_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    coef_wr && byte_cnt == `FFE_BYTE_LAST && wptr != `FFE_COEF_LAST
    |=> wptr == $past(wptr) + 7'h01 && byte_cnt == 2'h0)
    else $error("pointer did not advance on fourth byte");
  ptr_halt_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_full |-> wptr == `FFE_COEF_LAST && !coef_wr)
    else $error("write accepted past last entry");
  ptr_rewind_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_other || rd_other |=> wptr == 7'h00 && rptr == 9'h000)
    else $error("pointers not rewound");
  rd_blocks_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    coef_rd_en && wr_done |=> $stable(byte_cnt) || byte_cnt == 2'h0)
    else $error("store written while read enabled");
  rd_byte_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    coef_rd |=> rptr == $past(rptr) + 9'h001 &&
    config_byte_bus_out == $past(coef_mem[rptr[8:2]][7:0]) ||
    $past(rptr[1:0]) != 2'h0)
    else $error("wrong coefficient byte returned");
  rom_load_a: assert property (@(posedge ser_clk) disable iff (!nrst)
    sample_word_sync |=> rom_hold == $past(rom_out) &&
    rom_out == $past(next_rom))
    else $error("rom holding register not updated");
  rom_map_a: assert property (@(posedge ser_clk) disable iff (!nrst)
    sample_word_sync && mix_word_sync && mix_serial_in
    |=> rom_out == `FFE_ROM_POS)
    else $error("selector 11 must give plus one");
  mix_src_a: assert property (@(posedge ser_clk) disable iff (!nrst)
    sample_word_sync && !mix_fmt_s[`FFE_MIX_FMT_SERIAL_BIT]
    |=> mcand == $past(rom_hold))
    else $error("rom source not used");
  prod_cross_a: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    tgl_s != tgl_d |=> product_valid && product_data == $past(prod_hold))
    else $error("product not handed over");
  full_c: cover property (@(posedge sys_clk) disable iff (!nrst) wr_full);
  rd_c: cover property (@(posedge sys_clk) disable iff (!nrst) coef_rd);
  prod_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    product_valid);
  rom_c: cover property (@(posedge ser_clk) disable iff (!nrst)
    sample_word_sync && !mix_fmt_s[`FFE_MIX_FMT_SERIAL_BIT]);
endmodule : ffe_top
`default_nettype wire

// ### verification/ffe_link_partner.sv
`default_nettype none
module ffe_link_partner
(
  output logic ser_clk,
  output logic data_serial_in,
  output logic sample_word_sync,
  output logic mix_serial_in,
  output logic mix_word_sync
);
  timeunit 1ns;
  timeprecision 100ps;

  // the serial clock stands still between frames, except for a few
  // settle cycles that carry a new format into the link domain
  initial
  begin
    ser_clk = 1'b0;
    data_serial_in = 1'b0;
    sample_word_sync = 1'b0;
    mix_serial_in = 1'b0;
    mix_word_sync = 1'b0;
  end

  // one sync cycle, then the bits; spare cycles toggle the line on every clock
  task automatic send_frame(input logic [23:0] d, input int dl,
    input bit dmsb, input logic [23:0] m, input int ml, input bit mmsb,
    input bit rom, input logic [1:0] sel);
    int n;
    n = (dl > ml) ? dl : ml;
    for (int i = -1; i < n; i++)
    begin
      sample_word_sync = (i < 0);
      if (i >= 0 && i < dl)
        data_serial_in = dmsb ? d[dl-1-i] : d[i];
      else
        data_serial_in = ~data_serial_in;
      if (rom)
      begin
        mix_word_sync = sel[1];
        mix_serial_in = sel[0];
      end
      else
      begin
        mix_word_sync = (i < 0);
        if (i >= 0 && i < ml)
          mix_serial_in = mmsb ? m[ml-1-i] : m[i];
        else
          mix_serial_in = ~mix_serial_in;
      end
      #62.5 ser_clk = 1'b1;
      #62.5 ser_clk = 1'b0;
    end
    sample_word_sync = 1'b0;
    if (!rom)
      mix_word_sync = 1'b0;
  endtask : send_frame

  // clock pulses with the syncs left as they are; the formats cross on link clock edges only
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      #62.5 ser_clk = 1'b1;
      #62.5 ser_clk = 1'b0;
    end
  endtask : idle_clocks
endmodule : ffe_link_partner
`default_nettype wire

// ### verification/testbench.sv
`include "ffe_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk;
  logic nrst;
  logic [2:0] reg_sel;
  logic [7:0] host_data;
  logic wr_n;
  logic rd_n;
  logic [6:0] coef_addr;
  logic [7:0] bus_out;
  logic bus_oe;
  wire logic [7:0] cfg_bus;
  ffe_pkg::ffe_coef_type coef_data;
  ffe_pkg::ffe_prod_type prod;
  logic prod_valid;
  logic ser_clk;
  logic din;
  logic ssync;
  logic mdin;
  logic msync;
  int n_errors;
  int tests_run;
  logic [47:0] prods[$];
  logic [31:0] coefs[130];
  logic [7:0] b;

  // shared byte bus: the device wins while it drives, else the host
  assign cfg_bus = bus_oe ? bus_out : host_data;

  ffe_top dut (.sys_clk(sys_clk), .nrst(nrst), .reg_select_pins(reg_sel),
    .config_byte_bus_in(cfg_bus), .config_byte_bus_out(bus_out),
    .config_byte_bus_oe(bus_oe), .wr_n(wr_n), .rd_n(rd_n),
    .coef_rd_addr(coef_addr), .coef_rd_data(coef_data), .ser_clk(ser_clk),
    .data_serial_in(din), .sample_word_sync(ssync), .mix_serial_in(mdin),
    .mix_word_sync(msync), .product_data(prod),
    .product_valid(prod_valid));

  ffe_link_partner partner (.ser_clk(ser_clk), .data_serial_in(din),
    .sample_word_sync(ssync), .mix_serial_in(mdin), .mix_word_sync(msync));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // collect every product handed over to sys_clk
  always @(negedge sys_clk)
    if (prod_valid === 1'b1)
      prods.push_back(prod);

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // strobes are synced inside, so hold everything well past 3 edges
  task automatic host_write(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_sel = a;
    host_data = d;
    wr_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    wr_n = 1'b1;
    repeat (5) @(negedge sys_clk);
  endtask : host_write

  task automatic host_read(input logic [2:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_sel = a;
    repeat (4) @(negedge sys_clk);
    rd_n = 1'b0; // wr_n is already high here
    repeat (6) @(negedge sys_clk);
    check(48'(bus_oe), 48'h1);
    d = cfg_bus;
    rd_n = 1'b1;
    repeat (5) @(negedge sys_clk);
  endtask : host_read

  task automatic peek(input logic [6:0] idx, input logic [31:0] exp);
    @(negedge sys_clk);
    coef_addr = idx;
    repeat (2) @(negedge sys_clk);
    check(48'(coef_data), 48'(exp));
  endtask : peek

  function automatic logic [23:0] rom_val(input logic [1:0] sel);
    case (sel)
      2'b01: return `FFE_ROM_NEG;
      2'b11: return `FFE_ROM_POS;
      default: return `FFE_ROM_ZERO;
    endcase
  endfunction : rom_val

  // msb aligned sample, offset binary flips the top bit, full product
  function automatic logic [47:0] exp_prod(input logic [23:0] d,
    input int dl, input bit offs, input logic [23:0] mix);
    logic [23:0] a;
    logic signed [47:0] x;
    logic signed [47:0] y;
    a = d << (24 - dl);
    if (offs)
      a[23] = ~a[23];
    x = {{24{a[23]}}, a};
    y = {{24{mix[23]}}, mix};
    return x * y;
  endfunction : exp_prod

  // six frames; product of sync s uses word s-1 with mix word s-1, or the rom selector of frame s-2
  task automatic run_batch(input bit ser, input bit pass, input int dl,
    input bit dmsb, input bit offs, input int ml, input bit mmsb);
    logic [23:0] w[6];
    logic [23:0] m[6];
    logic [23:0] mix;
    int first;
    int base;
    host_write(`FFE_REG_IN_FMT, {1'b0, dmsb, offs, 5'(dl)});
    host_read(`FFE_REG_IN_FMT, b);
    check(48'(b), 48'({1'b0, dmsb, offs, 5'(dl)}));
    host_write(`FFE_REG_MIX_FMT, {1'b0, ser, mmsb, 5'(ml)});
    // the formats reach the link domain only on its own clock edges
    partner.idle_clocks(2);
    prods.delete();
    for (int s = 0; s < 6; s++)
    begin
      w[s] = 24'($urandom) & ((24'h1 << dl) - 24'h1);
      m[s] = 24'($urandom) & ((24'h1 << ml) - 24'h1);
      partner.send_frame(w[s], dl, dmsb, m[s], ml, mmsb, !ser,
        pass ? 2'h3 : 2'(s));
    end
    repeat (12) @(negedge sys_clk);
    first = ser ? 1 : 2;
    base = prods.size() - (6 - first);
    check(48'(base >= 0), 48'h1);
    for (int s = first; s < 6 && base >= 0; s++)
    begin
      mix = ser ? m[s-1] << (24 - ml) : rom_val(pass ? 2'h3 : 2'(s - 2));
      check(prods[base+s-first], exp_prod(w[s-1], dl, offs, mix));
    end
  endtask : run_batch

  // hang guard, sized well above the expected run of about 82 us
  initial
  begin
    #250000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    nrst = 1'b0;
    reg_sel = 3'h0;
    host_data = 8'h00;
    wr_n = 1'b1;
    rd_n = 1'b1;
    coef_addr = 7'h00;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(32'hb6bbd773));
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    host_read(`FFE_REG_IN_FMT, b);
    check(48'(b), 48'(`FFE_REG_RESET));
    host_write(`FFE_REG_FILTER_CFG, 8'h00);
    // all 128 taps asymmetric: twice the count wraps the length byte to 0
    host_write(`FFE_REG_FILTER_LEN, 8'h00);
    // a partial word is dropped by the read of another register
    host_write(`FFE_REG_COEF_PORT, 8'hA5);
    host_write(`FFE_REG_COEF_PORT, 8'h3C);
    host_read(`FFE_REG_IN_FMT, b);
    for (int i = 0; i < 130; i++)
    begin
      coefs[i] = $urandom;
      for (int k = 0; k < 4; k++)
        host_write(`FFE_REG_COEF_PORT, coefs[i][8*k +: 8]);
    end
    peek(7'h00, coefs[0]);
    peek(7'h01, coefs[1]);
    peek(`FFE_COEF_LAST, coefs[127]);
    host_write(`FFE_REG_FILTER_CFG, 8'h10);
    repeat (4) host_write(`FFE_REG_COEF_PORT, 8'h5A);
    peek(7'h00, coefs[0]);
    for (int i = 0; i < 8; i++)
    begin
      host_read(`FFE_REG_COEF_PORT, b);
      check(48'(b), 48'(coefs[i/4][8*(i%4) +: 8]));
    end
    host_write(`FFE_REG_IN_FMT, 8'h08);
    host_read(`FFE_REG_COEF_PORT, b);
    check(48'(b), 48'(coefs[0][7:0]));
    // a 17-tap symmetric set loads only its nine unique words
    host_write(`FFE_REG_FILTER_CFG, 8'h00);
    host_write(`FFE_REG_FILTER_LEN, 8'h11);
    for (int i = 0; i < 9; i++)
    begin
      coefs[i] = $urandom;
      for (int k = 0; k < 4; k++)
        host_write(`FFE_REG_COEF_PORT, coefs[i][8*k +: 8]);
    end
    host_read(`FFE_REG_COEF_PORT, b);
    check(48'(b), 48'h0);
    peek(7'h08, coefs[8]);
    peek(7'h09, coefs[9]);
    // rom pass-through, rom sinusoid, then serial mix of two lengths
    run_batch(1'b0, 1'b1, 24, 1'b1, 1'b0, 0, 1'b0);
    run_batch(1'b0, 1'b0, 8, 1'b0, 1'b1, 0, 1'b0);
    run_batch(1'b1, 1'b0, 13, 1'b1, 1'b0, 8, 1'b0);
    run_batch(1'b1, 1'b0, 24, 1'b0, 1'b1, 24, 1'b1);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
